// file: design/power_stage_cfg_pkg.sv
`default_nettype none
package power_stage_cfg_pkg;

  localparam logic [7:0] MFR_CFG_CODE = 8'hD0;
  localparam logic [7:0] USER_CFG_CODE = 8'hD1;
  localparam logic [15:0] MFR_CFG_RESET = 16'h6A11;
  localparam logic [15:0] USER_CFG_RESET = 16'h2011;
  localparam logic [15:0] MFR_CFG_MASK = 16'hFFFF;
  localparam logic [15:0] USER_CFG_MASK = 16'hEB67;

  // Manufacturer word fields
  localparam int BLANK_MSB = 15;
  localparam int BLANK_LSB = 11;
  localparam int FCOUNT_MSB = 10;
  localparam int FCOUNT_LSB = 8;
  localparam int EXT_TEMP_EN_BIT = 7;
  localparam int TEMP_SEL_BIT = 6;
  localparam int SENSE_MSB = 5;
  localparam int SENSE_LSB = 4;
  localparam int NONLINEAR_RAMP_BIT = 3;
  localparam int ALT_RAMP_BIT = 2;
  localparam int GOOD_PIN_PP_BIT = 1;
  localparam int SYNC_PP_BIT = 0;

  // User word fields
  localparam int MIN_DUTY_MSB = 15;
  localparam int MIN_DUTY_LSB = 14;
  localparam int MIN_DUTY_EN_BIT = 13;
  localparam int SYNC_TO_BIT = 11;
  localparam int FEED_FWD_OFF_BIT = 9;
  localparam int SPREAD_BIT = 8;
  localparam int SYNC_UTIL_BIT = 6;
  localparam int SYNC_OUT_BIT = 5;
  localparam int LOW_SIDE_BIT = 2;
  localparam int STANDBY_MSB = 1;
  localparam int STANDBY_LSB = 0;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BLANK_STEP_NS = 32;
  localparam int SYNC_TIMEOUT_MS = 500;
  localparam int SYNC_TIMEOUT_CYCLES = SYNC_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SENSE_GND_DOWN = 2'b00,
    SENSE_VOUT_DOWN = 2'b01,
    SENSE_VOUT_UP = 2'b10
  } sense_scheme_e;

  typedef enum logic [1:0] {
    STBY_LOW_POWER = 2'b00,
    STBY_MONITOR = 2'b01,
    STBY_PULSED = 2'b11
  } standby_mode_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_s;

  typedef struct packed {
    logic drive;
    logic oe_n;
  } pin_drive_s;

endpackage : power_stage_cfg_pkg
`default_nettype wire

// file: design/power_stage_feature_config.sv
// Overview of operation
// - Blank current sense D times 32 ns
// - Fault after 2C+1 consecutive current violations
// - External temperature measured only when enabled
// - Select internal or external sensor for checks
// - Sense scheme select; code 11 reserved
// - Power good open drain or push-pull
// - Switch clock pin open drain or push-pull
// - Ramp duty floor (N+1)/256 when enabled
// - Switch clock stops 500 ms after disable
// - Supply feed-forward correction when bit clear
// - Spread mode 0: ignore or sequence down
// - Spread mode 1: shut down on group fault
// - Clock source auto or switch-clock input
// - Drive switch clock out from internal oscillator
// - Low-side held off or on while disabled
// - Standby mode sets disabled-state monitoring
`timescale 1ns/1ps
`default_nettype none
module power_stage_feature_config #(
  parameter int unsigned SYNC_TIMEOUT_CYCLES = power_stage_cfg_pkg::SYNC_TIMEOUT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire power_stage_cfg_pkg::cmd_s cmd_i,
  output logic cmd_ack_o,
  output logic cmd_nack_o,
  output logic [15:0] rd_data_o,
  input wire logic switch_edge_i,
  output logic blank_o,
  input wire logic sense_sample_i,
  input wire logic overcurrent_i,
  input wire logic undercurrent_i,
  output logic overcurrent_fault_o,
  output logic undercurrent_fault_o,
  output logic ext_temp_meas_en_o,
  input wire logic int_temp_over_i,
  input wire logic ext_temp_over_i,
  output logic temp_fault_o,
  output power_stage_cfg_pkg::sense_scheme_e sense_scheme_o,
  input wire logic power_good_i,
  output power_stage_cfg_pkg::pin_drive_s power_good_pin_o,
  input wire logic sync_pin_i,
  output power_stage_cfg_pkg::pin_drive_s sync_pin_o,
  input wire logic int_osc_clk_i,
  input wire logic sync_detected_i,
  output logic sw_clk_o,
  input wire logic enable_i,
  input wire logic ramp_i,
  input wire logic [7:0] duty_i,
  output logic [7:0] duty_o,
  output logic vdd_comp_en_o,
  input wire logic group_fault_i,
  input wire logic seq_en_i,
  output logic shutdown_now_o,
  output logic seq_down_o,
  input wire logic low_side_pwm_i,
  output logic low_side_o,
  output power_stage_cfg_pkg::standby_mode_e standby_mode_o,
  output logic telemetry_avail_o,
  output logic nonlinear_response_ramp_o,
  output logic alt_ramp_o
);

  logic [15:0] mfr_cfg;
  logic [15:0] user_cfg;
  logic hit_mfr;
  logic hit_user;

  assign hit_mfr = cmd_i.code == power_stage_cfg_pkg::MFR_CFG_CODE;
  assign hit_user = cmd_i.code == power_stage_cfg_pkg::USER_CFG_CODE;
  assign cmd_ack_o = cmd_i.valid && (hit_mfr || hit_user);
  assign cmd_nack_o = cmd_i.valid && !(hit_mfr || hit_user);

  // Word storage, reserved positions forced to zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mfr_cfg <= power_stage_cfg_pkg::MFR_CFG_RESET & power_stage_cfg_pkg::MFR_CFG_MASK;
      user_cfg <= power_stage_cfg_pkg::USER_CFG_RESET & power_stage_cfg_pkg::USER_CFG_MASK;
    end else if (cmd_i.valid && cmd_i.write) begin
      if (hit_mfr) begin
        mfr_cfg <= cmd_i.wdata & power_stage_cfg_pkg::MFR_CFG_MASK;
      end
      if (hit_user) begin
        user_cfg <= cmd_i.wdata & power_stage_cfg_pkg::USER_CFG_MASK;
      end
    end
  end

  // Read data
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_data_o <= 16'h0000;
    end else if (cmd_i.valid && !cmd_i.write) begin
      rd_data_o <= hit_mfr ? mfr_cfg : (hit_user ? user_cfg : 16'h0000);
    end
  end

  // Blanking window after each switching edge
  logic [4:0] blank_steps;
  logic [9:0] blank_limit_ns;
  logic [9:0] elapsed_ns;
  logic [10:0] next_elapsed;

  assign blank_steps = mfr_cfg[power_stage_cfg_pkg::BLANK_MSB:power_stage_cfg_pkg::BLANK_LSB];
  assign blank_limit_ns = 10'(blank_steps * power_stage_cfg_pkg::BLANK_STEP_NS);
  assign next_elapsed = {1'b0, elapsed_ns} + 11'(power_stage_cfg_pkg::CLK_PERIOD_NS);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      elapsed_ns <= 10'h3FF;
      blank_o <= 1'b0;
    end else if (switch_edge_i) begin
      elapsed_ns <= 10'h000;
      blank_o <= blank_limit_ns != 10'h000;
    end else begin
      elapsed_ns <= next_elapsed[10] ? 10'h3FF : next_elapsed[9:0];
      blank_o <= blank_o && (next_elapsed < {1'b0, blank_limit_ns});
    end
  end

  // Consecutive violation counters, one per direction
  logic [1:0] violation;
  logic [3:0] needed;

  assign violation = {undercurrent_i, overcurrent_i};
  assign needed = {mfr_cfg[power_stage_cfg_pkg::FCOUNT_MSB:power_stage_cfg_pkg::FCOUNT_LSB], 1'b1};

  for (genvar g = 0; g < 2; g++) begin : g_fault
    logic [3:0] run;
    logic [3:0] next_run;
    logic tripped;
    assign next_run = (run == 4'hF) ? 4'hF : run + 4'h1;
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        run <= 4'h0;
        tripped <= 1'b0;
      end else if (sense_sample_i) begin
        run <= violation[g] ? next_run : 4'h0;
        tripped <= violation[g] && (next_run >= needed);
      end
    end
  end

  assign overcurrent_fault_o = g_fault[0].tripped;
  assign undercurrent_fault_o = g_fault[1].tripped;

  // Static configuration decodes
  logic use_ext_clk;
  logic sync_timed_out;
  logic [31:0] off_count;
  logic [7:0] duty_floor;

  assign use_ext_clk = user_cfg[power_stage_cfg_pkg::SYNC_UTIL_BIT] || sync_detected_i;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ext_temp_meas_en_o <= 1'b0;
      temp_fault_o <= 1'b0;
      sense_scheme_o <= power_stage_cfg_pkg::SENSE_GND_DOWN;
      vdd_comp_en_o <= 1'b0;
      nonlinear_response_ramp_o <= 1'b0;
      alt_ramp_o <= 1'b0;
    end else begin
      ext_temp_meas_en_o <= mfr_cfg[power_stage_cfg_pkg::EXT_TEMP_EN_BIT];
      temp_fault_o <= mfr_cfg[power_stage_cfg_pkg::TEMP_SEL_BIT] ?
                      ext_temp_over_i : int_temp_over_i;
      unique case (mfr_cfg[power_stage_cfg_pkg::SENSE_MSB:power_stage_cfg_pkg::SENSE_LSB])
        2'b01: sense_scheme_o <= power_stage_cfg_pkg::SENSE_VOUT_DOWN;
        2'b10: sense_scheme_o <= power_stage_cfg_pkg::SENSE_VOUT_UP;
        default: sense_scheme_o <= power_stage_cfg_pkg::SENSE_GND_DOWN;
      endcase
      vdd_comp_en_o <= !user_cfg[power_stage_cfg_pkg::FEED_FWD_OFF_BIT];
      nonlinear_response_ramp_o <= mfr_cfg[power_stage_cfg_pkg::NONLINEAR_RAMP_BIT];
      alt_ramp_o <= mfr_cfg[power_stage_cfg_pkg::ALT_RAMP_BIT];
    end
  end

  // Power good pin drive
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      power_good_pin_o <= '{drive: 1'b0, oe_n: 1'b0};
    end else begin
      power_good_pin_o.drive <= power_good_i;
      power_good_pin_o.oe_n <= !mfr_cfg[power_stage_cfg_pkg::GOOD_PIN_PP_BIT] &&
                               power_good_i;
    end
  end

  // Switch clock time-out after disable
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      off_count <= 32'h0;
      sync_timed_out <= 1'b0;
    end else if (enable_i || !user_cfg[power_stage_cfg_pkg::SYNC_TO_BIT]) begin
      off_count <= 32'h0;
      sync_timed_out <= 1'b0;
    end else if (off_count < SYNC_TIMEOUT_CYCLES - 1) begin
      off_count <= off_count + 32'h1;
    end else begin
      sync_timed_out <= 1'b1;
    end
  end

  // Clock source and switch clock pin
  logic clk_out_en;
  assign clk_out_en = user_cfg[power_stage_cfg_pkg::SYNC_OUT_BIT] && !use_ext_clk && !sync_timed_out;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sw_clk_o <= 1'b0;
      sync_pin_o <= '{drive: 1'b0, oe_n: 1'b1};
    end else begin
      sw_clk_o <= sync_timed_out ? 1'b0 : (use_ext_clk ? sync_pin_i : int_osc_clk_i);
      sync_pin_o.drive <= int_osc_clk_i;
      sync_pin_o.oe_n <= !clk_out_en ||
                         (!mfr_cfg[power_stage_cfg_pkg::SYNC_PP_BIT] && int_osc_clk_i);
    end
  end

  // Minimum duty during ramps
  assign duty_floor = {6'h00, user_cfg[power_stage_cfg_pkg::MIN_DUTY_MSB:power_stage_cfg_pkg::MIN_DUTY_LSB]} + 8'h01;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      duty_o <= 8'h00;
    end else if (ramp_i && user_cfg[power_stage_cfg_pkg::MIN_DUTY_EN_BIT] && duty_i < duty_floor) begin
      duty_o <= duty_floor;
    end else begin
      duty_o <= duty_i;
    end
  end

  // Fault spreading
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      shutdown_now_o <= 1'b0;
      seq_down_o <= 1'b0;
    end else begin
      shutdown_now_o <= user_cfg[power_stage_cfg_pkg::SPREAD_BIT] && group_fault_i;
      seq_down_o <= !user_cfg[power_stage_cfg_pkg::SPREAD_BIT] && seq_en_i && group_fault_i;
    end
  end

  // Disabled-state behaviour
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      low_side_o <= 1'b0;
      standby_mode_o <= power_stage_cfg_pkg::STBY_LOW_POWER;
      telemetry_avail_o <= 1'b1;
    end else begin
      low_side_o <= enable_i ? low_side_pwm_i : user_cfg[power_stage_cfg_pkg::LOW_SIDE_BIT];
      unique case (user_cfg[power_stage_cfg_pkg::STANDBY_MSB:power_stage_cfg_pkg::STANDBY_LSB])
        2'b01: standby_mode_o <= power_stage_cfg_pkg::STBY_MONITOR;
        2'b11: standby_mode_o <= power_stage_cfg_pkg::STBY_PULSED;
        default: standby_mode_o <= power_stage_cfg_pkg::STBY_LOW_POWER;
      endcase
      telemetry_avail_o <= enable_i ||
                           user_cfg[power_stage_cfg_pkg::STANDBY_LSB];
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  blank_window_a: assert property (
    switch_edge_i && blank_steps == 5'd2 |=> blank_o [*4] ##1 !blank_o)
    else $error("blanking length wrong");
  fault_count_a: assert property (
    $rose(overcurrent_fault_o) |-> g_fault[0].run >= needed)
    else $error("overcurrent fault too early");
  ext_temp_a: assert property (
    ##1 ext_temp_meas_en_o == $past(mfr_cfg[7]))
    else $error("external temperature enable mismatch");
  temp_select_a: assert property (
    mfr_cfg[6] && !cmd_i.valid |=> temp_fault_o == $past(ext_temp_over_i))
    else $error("temperature source wrong");
  good_open_drain_a: assert property (
    !mfr_cfg[1] && !power_good_i && !cmd_i.valid |=> !power_good_pin_o.oe_n && !power_good_pin_o.drive)
    else $error("power good not pulled low");
  duty_floor_a: assert property (
    ramp_i && user_cfg[13] |=> duty_o >= $past(duty_floor))
    else $error("ramp duty below floor");
  spread_a: assert property (
    user_cfg[8] && group_fault_i |=> shutdown_now_o && !seq_down_o)
    else $error("group fault did not shut down");
  low_side_a: assert property (
    !enable_i && !cmd_i.valid |=> low_side_o == user_cfg[2])
    else $error("low side state wrong while disabled");
  readback_a: assert property (
    cmd_i.valid && cmd_i.write && hit_user |=>
      user_cfg == ($past(cmd_i.wdata) & power_stage_cfg_pkg::USER_CFG_MASK))
    else $error("user word readback wrong");
  timeout_a: assert property (
    sync_timed_out |-> off_count == SYNC_TIMEOUT_CYCLES - 1 && !$past(enable_i))
    else $error("switch clock timed out early");

  blank_seen_c: cover property (switch_edge_i ##1 blank_o);
  fault_seen_c: cover property ($rose(undercurrent_fault_o));
  timeout_seen_c: cover property ($rose(sync_timed_out));
  pulsed_mode_c: cover property (standby_mode_o == power_stage_cfg_pkg::STBY_PULSED);

endmodule : power_stage_feature_config
`default_nettype wire

// file: testbench/mgmt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input wire logic ref_clk_i,
  output power_stage_cfg_pkg::cmd_s cmd_o,
  input wire logic ack_i,
  input wire logic nack_i,
  input wire logic [15:0] rd_data_i
);
  initial cmd_o = '0;
  // One word command, held for the edge that takes it
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [1:0] resp, output logic [15:0] rd);
    logic [15:0] w;
    w = wd;
    if (wr && code == power_stage_cfg_pkg::MFR_CFG_CODE && w[6]) begin
      w[7] = 1'b1;
    end
    @(posedge ref_clk_i);
    #1;
    cmd_o = '{valid: 1'b1, write: wr, code: code, wdata: w};
    @(posedge ref_clk_i);
    resp = {ack_i, nack_i};
    #1;
    cmd_o = '0;
    rd = rd_data_i;
  endtask : xfer
endmodule : mgmt_host_model
`default_nettype wire

// file: testbench/power_stage_feature_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_stage_feature_config_bench;
  localparam logic [7:0] CODE_M = power_stage_cfg_pkg::MFR_CFG_CODE;
  localparam logic [7:0] CODE_U = power_stage_cfg_pkg::USER_CFG_CODE;
  int err_total = 0;
  int n_tests = 0;
  logic clk, srst, sw_edge, smp, over_in, under_in, it_ov, xt_ov, good_in, sync_in, osc;
  logic sync_det, en, ramp, gflt, seq_en, ls_pwm, ack, nack, blank, over_flt, under_flt;
  logic xt_en, t_f, sw_clk, vcomp, shut, seqd, ls, telem, nl_ramp, alt;
  logic [7:0] duty_in, duty_out;
  logic [15:0] rd;
  power_stage_cfg_pkg::cmd_s cmd;
  power_stage_cfg_pkg::sense_scheme_e scheme;
  power_stage_cfg_pkg::pin_drive_s good_pin, sync_pin;
  power_stage_cfg_pkg::standby_mode_e stby;

  mgmt_host_model host (.ref_clk_i(clk), .cmd_o(cmd), .ack_i(ack), .nack_i(nack),
    .rd_data_i(rd));

  power_stage_feature_config #(.SYNC_TIMEOUT_CYCLES(20)) DUT (
    .ref_clk_i(clk), .srst_i(srst), .cmd_i(cmd), .cmd_ack_o(ack), .cmd_nack_o(nack),
    .rd_data_o(rd), .switch_edge_i(sw_edge), .blank_o(blank), .sense_sample_i(smp),
    .overcurrent_i(over_in), .undercurrent_i(under_in), .overcurrent_fault_o(over_flt),
    .undercurrent_fault_o(under_flt), .ext_temp_meas_en_o(xt_en), .int_temp_over_i(it_ov),
    .ext_temp_over_i(xt_ov), .temp_fault_o(t_f), .sense_scheme_o(scheme),
    .power_good_i(good_in), .power_good_pin_o(good_pin), .sync_pin_i(sync_in),
    .sync_pin_o(sync_pin), .int_osc_clk_i(osc), .sync_detected_i(sync_det),
    .sw_clk_o(sw_clk), .enable_i(en), .ramp_i(ramp), .duty_i(duty_in), .duty_o(duty_out),
    .vdd_comp_en_o(vcomp), .group_fault_i(gflt), .seq_en_i(seq_en),
    .shutdown_now_o(shut), .seq_down_o(seqd), .low_side_pwm_i(ls_pwm), .low_side_o(ls),
    .standby_mode_o(stby), .telemetry_avail_o(telem), .nonlinear_response_ramp_o(nl_ramp),
    .alt_ramp_o(alt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cfg(input logic [15:0] m, input logic [15:0] u);
    logic [1:0] r;
    logic [15:0] q;
    host.xfer(1'b1, CODE_M, m, r, q);
    host.xfer(1'b1, CODE_U, u, r, q);
    tick(2);
  endtask : cfg

  task automatic t_regs();
    logic [1:0] r;
    logic [15:0] q;
    host.xfer(1'b0, CODE_M, 16'h0000, r, q);
    check("mfr reset", q, 16'h6A11);
    check("mfr ack", 16'(r), 16'h0002);
    host.xfer(1'b0, CODE_U, 16'h0000, r, q);
    check("user reset", q, 16'h2001);
    host.xfer(1'b0, 8'hD5, 16'h0000, r, q);
    check("unmapped data", q, 16'h0000);
    check("unmapped nack", 16'(r), 16'h0001);
    host.xfer(1'b1, CODE_M, 16'hFFFF, r, q);
    host.xfer(1'b1, CODE_U, 16'hFFFF, r, q);
    host.xfer(1'b0, CODE_M, 16'h0000, r, q);
    check("mfr back", q, 16'hFFFF);
    host.xfer(1'b0, CODE_U, 16'h0000, r, q);
    check("user back", q, 16'hEB67);
    check("stored bits", 16'({nl_ramp, alt}), 16'h0003);
  endtask : t_regs

  task automatic t_blank();
    int n;
    for (int d = 0; d <= 5; d += (d == 0) ? 2 : 3) begin
      cfg({d[4:0], 11'h000}, 16'h2001);
      sw_edge = 1'b1;
      tick(1);
      sw_edge = 1'b0;
      n = 0;
      repeat (12) begin
        if (blank === 1'b1) n++;
        tick(1);
      end
      check("blank cycles", 16'(n), 16'((d * 32 + 19) / 20));
    end
  endtask : t_blank

  task automatic t_fault();
    logic [6:0] pat;
    pat = 7'b0111011;
    cfg(16'h0100, 16'h2001);
    for (int i = 0; i < 7; i++) begin
      over_in = pat[i];
      under_in = pat[6 - i];
      smp = 1'b1;
      tick(1);
      smp = 1'b0;
      check("over fault", 16'(over_flt), 16'(i == 5));
      check("under fault", 16'(under_flt), 16'(i == 3));
      tick(1);
    end
  endtask : t_fault

  task automatic t_temp();
    it_ov = 1'b1;
    xt_ov = 1'b0;
    for (int k = 0; k < 4; k++) begin
      cfg({8'h00, k > 0, k == 2, k[1:0], 4'h0}, 16'h2001);
      tick(1);
      check("ext meas", 16'(xt_en), 16'(k > 0));
      check("temp fault", 16'(t_f), 16'(k != 2));
      check("scheme", 16'(scheme), 16'((k == 3) ? 0 : k));
    end
  endtask : t_temp

  task automatic t_pins();
    en = 1'b1;
    for (int p = 0; p < 2; p++) begin
      cfg({14'h0000, p[0], p[0]}, 16'h0021);
      for (int v = 0; v < 2; v++) begin
        good_in = v[0];
        osc = v[0];
        tick(2);
        check("good oe_n", 16'(good_pin.oe_n), 16'(p == 0 && v == 1));
        check("sync oe_n", 16'(sync_pin.oe_n), 16'(p == 0 && v == 1));
        if (p == 1 || v == 0) begin
          check("good drive", 16'(good_pin.drive), 16'(v));
          check("sync drive", 16'(sync_pin.drive), 16'(v));
        end
      end
    end
    cfg(16'h0000, 16'h0001);
    check("sync input only", 16'(sync_pin.oe_n), 16'h0001);
  endtask : t_pins

  task automatic t_clk();
    osc = 1'b1;
    cfg(16'h0000, 16'h0821);
    check("int clk", 16'(sw_clk), 16'h0001);
    sync_det = 1'b1;
    tick(2);
    check("auto ext clk", 16'(sw_clk), 16'h0000);
    sync_det = 1'b0;
    cfg(16'h0000, 16'h0861);
    check("sync in clk", 16'(sw_clk), 16'h0000);
    cfg(16'h0000, 16'h0821);
    en = 1'b0;
    tick(10);
    check("pre timeout", 16'(sw_clk), 16'h0001);
    tick(15);
    check("timeout", 16'(sw_clk), 16'h0000);
    check("sync off", 16'(sync_pin.oe_n), 16'h0001);
    en = 1'b1;
    cfg(16'h0000, 16'h0021);
    en = 1'b0;
    tick(30);
    check("no timeout", 16'(sw_clk), 16'h0001);
  endtask : t_clk

  task automatic t_misc();
    en = 1'b1;
    ramp = 1'b1;
    duty_in = 8'h01;
    cfg(16'h0000, 16'hE001);
    check("duty floor", 16'(duty_out), 16'h0004);
    duty_in = 8'h09;
    tick(2);
    check("duty high", 16'(duty_out), 16'h0009);
    duty_in = 8'h01;
    ramp = 1'b0;
    tick(2);
    check("duty no ramp", 16'(duty_out), 16'h0001);
    ramp = 1'b1;
    cfg(16'h0000, 16'hC201);
    check("duty off", 16'(duty_out), 16'h0001);
    check("ff off", 16'(vcomp), 16'h0000);
    gflt = 1'b1;
    seq_en = 1'b1;
    cfg(16'h0000, 16'h0101);
    check("ff on", 16'(vcomp), 16'h0001);
    check("spread shut", 16'(shut), 16'h0001);
    cfg(16'h0000, 16'h0001);
    check("seq down", 16'({shut, seqd}), 16'h0001);
    seq_en = 1'b0;
    tick(2);
    check("ignore", 16'({shut, seqd}), 16'h0000);
    en = 1'b0;
    cfg(16'h0000, 16'h0005);
    check("low side on", 16'(ls), 16'h0001);
    ls_pwm = 1'b1;
    cfg(16'h0000, 16'h0001);
    check("low side off", 16'(ls), 16'h0000);
    for (int s = 0; s < 4; s++) begin
      cfg(16'h0000, 16'(s));
      check("standby", 16'(stby), 16'((s == 2) ? 0 : s));
      check("telemetry", 16'(telem), 16'(s % 2));
    end
  endtask : t_misc

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial begin
    #100us;
    err_total++;
    stop_test();
  end

  initial begin
    {srst, sw_edge, smp, over_in, under_in, it_ov, xt_ov} = 7'h40;
    {good_in, sync_in, osc, sync_det} = 4'h0;
    {en, ramp, gflt, seq_en, ls_pwm, duty_in} = 13'h0000;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    t_regs();
    t_blank();
    t_fault();
    t_temp();
    t_pins();
    t_clk();
    t_misc();
    stop_test();
  end
endmodule : power_stage_feature_config_bench
`default_nettype wire
